// ===== rtl/tcosp_pkg.sv
// Package of register offsets, field positions and codes for the one-shot pulse timer pair.
package tcosp_pkg;
	localparam logic [7:0] TCOSP_OFF_CTRL = 8'h00;
	localparam logic [7:0] TCOSP_OFF_MODE_LEAD = 8'h04;
	localparam logic [7:0] TCOSP_OFF_MODE_FOLLOW = 8'h08;
	localparam logic [7:0] TCOSP_OFF_DELAY_RELOAD = 8'h0C;
	localparam logic [7:0] TCOSP_OFF_WIDTH_RELOAD = 8'h10;
	localparam logic [7:0] TCOSP_OFF_OUT_VALUE = 8'h14;
	localparam logic [7:0] TCOSP_OFF_OUT_ENABLE = 8'h18;
	localparam logic [7:0] TCOSP_OFF_OUT_POLARITY = 8'h1C;
	localparam logic [7:0] TCOSP_OFF_OUT_ROLE = 8'h20;
	localparam logic [7:0] TCOSP_OFF_START = 8'h24;
	localparam logic [7:0] TCOSP_OFF_STOP = 8'h28;
	localparam logic [7:0] TCOSP_OFF_STATUS = 8'h2C;
	localparam logic [7:0] TCOSP_OFF_DELAY_COUNT = 8'h30;
	localparam logic [7:0] TCOSP_OFF_WIDTH_COUNT = 8'h34;
	localparam logic [7:0] TCOSP_OFF_PRESCALE = 8'h38;
	// Mode register field positions.
	localparam int TCOSP_MD_LO = 0;
	localparam int TCOSP_MD_HI = 3;
	localparam int TCOSP_TER_BIT = 4;
	localparam int TCOSP_CIS_LO = 6;
	localparam int TCOSP_CIS_HI = 7;
	localparam int TCOSP_STS_LO = 8;
	localparam int TCOSP_STS_HI = 10;
	localparam int TCOSP_CKS_LO = 14;
	localparam int TCOSP_CKS_HI = 15;
	// Bit positions of the two channels in output, start, stop and status registers.
	localparam int TCOSP_LEAD_BIT = 0;
	localparam int TCOSP_FOLLOW_BIT = 1;
	localparam int TCOSP_UNIT_EN_BIT = 0;
	localparam logic [3:0] TCOSP_MD_ONE_COUNT = 4'h8;
	localparam logic [2:0] TCOSP_STS_PIN = 3'h1;
	localparam logic [2:0] TCOSP_STS_LEAD_IRQ = 3'h4;
	localparam logic [1:0] TCOSP_EDGE_FALL = 2'h0;
	localparam logic [1:0] TCOSP_EDGE_RISE = 2'h1;
	localparam logic [1:0] TCOSP_EDGE_BOTH = 2'h2;
	localparam logic [1:0] TCOSP_CKS_A = 2'h0;
	localparam logic [1:0] TCOSP_CKS_B = 2'h2;
	localparam logic [15:0] TCOSP_ZERO16 = 16'h0000;
	localparam logic [15:0] TCOSP_ONE16 = 16'h0001;
	localparam logic [15:0] TCOSP_PRESCALE_RST = 16'h0000;
	typedef enum logic [1:0] {TCOSP_IDLE, TCOSP_WAIT, TCOSP_COUNT} tcosp_state_e;
endpackage

// ===== rtl/tcosp_prescaler.sv
// Prescaler that turns the system clock into single-cycle count enables.
`timescale 1ns/1ps
module tcosp_prescaler #(
	parameter int WIDTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [WIDTH-1:0] div_a,
	input wire logic [WIDTH-1:0] div_b,
	output logic tick_a,
	output logic tick_b
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt_a;
		logic [WIDTH-1:0] cnt_b;
		logic tick_a;
		logic tick_b;
	} tcosp_pre_s;
	tcosp_pre_s st_reg;
	tcosp_pre_s st_next;
	// A divider value of N yields one enable pulse every N+1 system clocks.
	always_comb
	begin
		st_next = st_reg;
		st_next.tick_a = 1'b0;
		st_next.tick_b = 1'b0;
		if (!run)
		begin
			st_next.cnt_a = '0;
			st_next.cnt_b = '0;
		end
		else
		begin
			if (st_reg.cnt_a >= div_a)
			begin
				st_next.cnt_a = '0;
				st_next.tick_a = 1'b1;
			end
			else
				st_next.cnt_a = st_reg.cnt_a + 1'b1;
			if (st_reg.cnt_b >= div_b)
			begin
				st_next.cnt_b = '0;
				st_next.tick_b = 1'b1;
			end
			else
				st_next.cnt_b = st_reg.cnt_b + 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign tick_a = st_reg.tick_a;
	assign tick_b = st_reg.tick_b;

	property p_ticks_stop;
		@(posedge pclk) disable iff (!presetn)
		!run |=> (!tick_a && !tick_b);
	endproperty
	a_ticks_stop: assert property (p_ticks_stop) else $error("count enable while unit stopped");
	property p_tick_single;
		@(posedge pclk) disable iff (!presetn)
		(tick_b && div_b != '0) |=> !tick_b;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("count enable longer than one cycle");
endmodule

// ===== rtl/tcosp_top.sv
// One-shot delayed pulse generator built from a lead and a follower down-counter, with an APB register file.
// Contract
// - Delay equals lead reload plus two counts.
// - Pulse width equals follower reload counts.
// - Lead one-count mode; trigger loads reload value.
// - Lead decrements per count; zero raises irq, holds.
// - Follower loads on lead irq, counts, irqs.
// - Output active one count after lead irq.
// - Software lead start bit also triggers; here only while the lead is already running.
// - Edge select: fall, rise, both; 11 prohibited.
// - Trigger source code 001 selects pin edge.
// - Follower source 100 selects lead irq.
// - Triggers ignored while a channel counts; a lead soft start restarts the lead, a lead irq pends until follower ends.
// - Polarity bit: 0 high, 1 low active.
// - Follower output role bit selects pulse output.
// - Output enable lets counting drive output.
// - Both starts set running, wait, self-clear.
// - Both stops clear running, hold values.
// - Output disabled drives stored output bit.
// - Unit disable resets all, clears output.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module tcosp_top #(
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trigger_in,
	output logic pulse_out,
	output logic pulse_out_oe,
	output logic delay_done_irq,
	output logic width_done_irq
);
	import tcosp_pkg::*;
	typedef struct packed {
		logic unit_en;
		logic [15:0] mode_lead;
		logic [15:0] mode_follow;
		logic [CNT_W-1:0] delay_reload_value;
		logic [CNT_W-1:0] width_reload_value;
		logic [1:0] out_value;
		logic [1:0] out_enable;
		logic [1:0] out_polarity;
		logic [1:0] out_role;
		logic [15:0] div_a;
		logic [15:0] div_b;
		logic lead_running_flag;
		logic follow_running_flag;
		tcosp_state_e lead_state;
		tcosp_state_e follow_state;
		logic [CNT_W-1:0] delay_down_counter;
		logic [CNT_W-1:0] width_down_counter;
		logic soft_start;
		logic lead_irq_pend;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pulse_out;
		logic pulse_out_oe;
		logic delay_done_irq;
		logic width_done_irq;
	} tcosp_top_s;

	tcosp_top_s st_reg;
	tcosp_top_s st_next;
	logic tick_a;
	logic tick_b;

	tcosp_prescaler #(.WIDTH(16)) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.run(st_reg.unit_en),
		.div_a(st_reg.div_a),
		.div_b(st_reg.div_b),
		.tick_a(tick_a),
		.tick_b(tick_b)
	);

	function automatic logic count_tick(input logic [15:0] mode, input logic ta, input logic tb);
		count_tick = (mode[TCOSP_CKS_HI:TCOSP_CKS_LO] == TCOSP_CKS_B) ? tb : ta;
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		case (sel)
			TCOSP_EDGE_FALL: edge_hit = prev & ~cur;
			TCOSP_EDGE_RISE: edge_hit = ~prev & cur;
			TCOSP_EDGE_BOTH: edge_hit = prev ^ cur;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] zext16(input logic [15:0] v);
		zext16 = {16'h0000, v};
	endfunction

	logic apb_wr;
	logic apb_rd;
	logic lead_tick;
	logic follow_tick;
	logic lead_trig;
	logic follow_trig;
	logic pin_edge;
	logic lead_one_count;
	logic follow_one_count;
	logic [CNT_W-1:0] wr_cnt;

	assign apb_wr = psel & penable & pwrite & ~st_reg.pready;
	assign apb_rd = psel & penable & ~pwrite & ~st_reg.pready;
	assign wr_cnt = pwdata[CNT_W-1:0];

	always_comb
	begin
		st_next = st_reg;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		st_next.delay_done_irq = 1'b0;
		st_next.width_done_irq = 1'b0;
		st_next.soft_start = 1'b0;
		st_next.pin_s1 = trigger_in;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_prev = st_reg.pin_s2;
		lead_tick = count_tick(st_reg.mode_lead, tick_a, tick_b);
		follow_tick = count_tick(st_reg.mode_follow, tick_a, tick_b);
		lead_one_count = st_reg.mode_lead[TCOSP_MD_HI:TCOSP_MD_LO] == TCOSP_MD_ONE_COUNT;
		follow_one_count = st_reg.mode_follow[TCOSP_MD_HI:TCOSP_MD_LO] == TCOSP_MD_ONE_COUNT;
		pin_edge = edge_hit(st_reg.mode_lead[TCOSP_CIS_HI:TCOSP_CIS_LO], st_reg.pin_prev, st_reg.pin_s2);
		lead_trig = st_reg.soft_start
			| (pin_edge && st_reg.mode_lead[TCOSP_STS_HI:TCOSP_STS_LO] == TCOSP_STS_PIN);
		follow_trig = st_reg.lead_irq_pend
			&& st_reg.mode_follow[TCOSP_STS_HI:TCOSP_STS_LO] == TCOSP_STS_LEAD_IRQ;

		// Lead channel: a trigger loads the reload value at once, reload plus one enables reach the
		// zero interrupt and the follower start adds one more, so the pulse starts reload plus two counts later.
		if (st_reg.lead_running_flag && lead_one_count)
		begin
			case (st_reg.lead_state)
				TCOSP_WAIT:
				begin
					if (lead_trig)
					begin
						st_next.lead_state = TCOSP_COUNT;
						st_next.delay_down_counter = st_reg.delay_reload_value;
					end
				end
				TCOSP_COUNT:
				begin
					// A new trigger while counting is dropped unless restart is allowed.
					if (lead_trig && st_reg.mode_lead[TCOSP_TER_BIT])
						st_next.delay_down_counter = st_reg.delay_reload_value;
					else if (lead_tick)
					begin
						if (st_reg.delay_down_counter == TCOSP_ZERO16[CNT_W-1:0])
						begin
							st_next.delay_done_irq = 1'b1;
							st_next.lead_irq_pend = 1'b1;
							st_next.lead_state = TCOSP_WAIT;
						end
						else
							st_next.delay_down_counter = st_reg.delay_down_counter - 1'b1;
					end
				end
				default: st_next.lead_state = TCOSP_WAIT;
			endcase
		end

		// Follower: the lead interrupt is consumed at the next follower count enable that finds the follower
		// not counting (or restart allowed), so the output goes active one count after it.
		if (st_reg.follow_running_flag && follow_one_count && follow_tick)
		begin
			if (follow_trig && (st_reg.follow_state != TCOSP_COUNT
				|| st_reg.mode_follow[TCOSP_TER_BIT]))
			begin
				st_next.lead_irq_pend = st_next.delay_done_irq;
				st_next.follow_state = TCOSP_COUNT;
				st_next.width_down_counter = st_reg.width_reload_value;
				if (st_reg.out_role[TCOSP_FOLLOW_BIT] && st_reg.out_enable[TCOSP_FOLLOW_BIT])
					st_next.out_value[TCOSP_FOLLOW_BIT] = ~st_reg.out_polarity[TCOSP_FOLLOW_BIT];
				if (st_reg.width_reload_value == TCOSP_ZERO16[CNT_W-1:0])
				begin
					st_next.follow_state = TCOSP_WAIT;
					st_next.width_down_counter = TCOSP_ZERO16[CNT_W-1:0];
					st_next.width_done_irq = 1'b1;
					if (st_reg.out_role[TCOSP_FOLLOW_BIT] && st_reg.out_enable[TCOSP_FOLLOW_BIT])
						st_next.out_value[TCOSP_FOLLOW_BIT] = st_reg.out_polarity[TCOSP_FOLLOW_BIT];
				end
			end
			else if (st_reg.follow_state == TCOSP_COUNT)
			begin
				if (st_reg.width_down_counter == TCOSP_ONE16[CNT_W-1:0]
					|| st_reg.width_down_counter == TCOSP_ZERO16[CNT_W-1:0])
				begin
					st_next.width_down_counter = TCOSP_ZERO16[CNT_W-1:0];
					st_next.follow_state = TCOSP_WAIT;
					st_next.width_done_irq = 1'b1;
					if (st_reg.out_role[TCOSP_FOLLOW_BIT] && st_reg.out_enable[TCOSP_FOLLOW_BIT])
						st_next.out_value[TCOSP_FOLLOW_BIT] = st_reg.out_polarity[TCOSP_FOLLOW_BIT];
				end
				else
					st_next.width_down_counter = st_reg.width_down_counter - 1'b1;
			end
		end

		// Register writes follow hardware updates, so software output writes win.
		if (apb_wr)
		begin
			case (paddr)
				TCOSP_OFF_CTRL: st_next.unit_en = pwdata[TCOSP_UNIT_EN_BIT];
				TCOSP_OFF_MODE_LEAD: st_next.mode_lead = pwdata[15:0];
				TCOSP_OFF_MODE_FOLLOW: st_next.mode_follow = pwdata[15:0];
				TCOSP_OFF_DELAY_RELOAD: st_next.delay_reload_value = wr_cnt;
				TCOSP_OFF_WIDTH_RELOAD: st_next.width_reload_value = wr_cnt;
				TCOSP_OFF_OUT_VALUE: st_next.out_value = pwdata[1:0];
				TCOSP_OFF_OUT_ENABLE: st_next.out_enable = pwdata[1:0];
				TCOSP_OFF_OUT_POLARITY: st_next.out_polarity = pwdata[1:0];
				TCOSP_OFF_OUT_ROLE: st_next.out_role = pwdata[1:0];
				TCOSP_OFF_PRESCALE: {st_next.div_b, st_next.div_a} = pwdata;
				TCOSP_OFF_START:
				begin
					// Start bits are not stored, so they read back as zero.
					if (pwdata[TCOSP_LEAD_BIT])
					begin
						st_next.lead_running_flag = 1'b1;
						st_next.lead_state = TCOSP_WAIT;
					end
					if (pwdata[TCOSP_FOLLOW_BIT])
					begin
						st_next.follow_running_flag = 1'b1;
						st_next.follow_state = TCOSP_WAIT;
						st_next.lead_irq_pend = 1'b0;
					end
				end
				TCOSP_OFF_STOP:
				begin
					if (pwdata[TCOSP_LEAD_BIT])
					begin
						st_next.lead_running_flag = 1'b0;
						st_next.lead_state = TCOSP_IDLE;
						st_next.delay_down_counter = st_reg.delay_down_counter;
					end
					if (pwdata[TCOSP_FOLLOW_BIT])
					begin
						st_next.follow_running_flag = 1'b0;
						st_next.follow_state = TCOSP_IDLE;
						st_next.width_down_counter = st_reg.width_down_counter;
						st_next.out_value = st_reg.out_value;
					end
				end
				TCOSP_OFF_STATUS, TCOSP_OFF_DELAY_COUNT, TCOSP_OFF_WIDTH_COUNT: ;
				default: st_next.pslverr = 1'b1;
			endcase
			// A software start on the lead channel acts as its trigger only if the lead is already running.
			if (paddr == TCOSP_OFF_START && pwdata[TCOSP_LEAD_BIT] && st_reg.lead_running_flag)
				st_next.soft_start = 1'b1;
			st_next.pready = 1'b1;
		end

		if (apb_rd)
		begin
			st_next.pready = 1'b1;
			case (paddr)
				TCOSP_OFF_CTRL: st_next.prdata = {31'h00000000, st_reg.unit_en};
				TCOSP_OFF_MODE_LEAD: st_next.prdata = zext16(st_reg.mode_lead);
				TCOSP_OFF_MODE_FOLLOW: st_next.prdata = zext16(st_reg.mode_follow);
				TCOSP_OFF_DELAY_RELOAD: st_next.prdata = zext16(16'(st_reg.delay_reload_value));
				TCOSP_OFF_WIDTH_RELOAD: st_next.prdata = zext16(16'(st_reg.width_reload_value));
				TCOSP_OFF_OUT_VALUE: st_next.prdata = {30'h00000000, st_reg.out_value};
				TCOSP_OFF_OUT_ENABLE: st_next.prdata = {30'h00000000, st_reg.out_enable};
				TCOSP_OFF_OUT_POLARITY: st_next.prdata = {30'h00000000, st_reg.out_polarity};
				TCOSP_OFF_OUT_ROLE: st_next.prdata = {30'h00000000, st_reg.out_role};
				TCOSP_OFF_PRESCALE: st_next.prdata = {st_reg.div_b, st_reg.div_a};
				TCOSP_OFF_STATUS: st_next.prdata = {30'h00000000, st_reg.follow_running_flag,
					st_reg.lead_running_flag};
				TCOSP_OFF_DELAY_COUNT: st_next.prdata = zext16(16'(st_reg.delay_down_counter));
				TCOSP_OFF_WIDTH_COUNT: st_next.prdata = zext16(16'(st_reg.width_down_counter));
				TCOSP_OFF_START, TCOSP_OFF_STOP: st_next.prdata = 32'h00000000;
				default:
				begin
					st_next.prdata = 32'h00000000;
					st_next.pslverr = 1'b1;
				end
			endcase
		end

		// Unit disable: everything but the enable, the pin synchroniser stages and the bus answer returns to reset.
		if (!st_next.unit_en)
		begin
			st_next.mode_lead = '0;
			st_next.mode_follow = '0;
			st_next.delay_reload_value = '0;
			st_next.width_reload_value = '0;
			st_next.out_value = '0;
			st_next.out_enable = '0;
			st_next.out_polarity = '0;
			st_next.out_role = '0;
			st_next.div_a = TCOSP_PRESCALE_RST;
			st_next.div_b = TCOSP_PRESCALE_RST;
			st_next.lead_running_flag = 1'b0;
			st_next.follow_running_flag = 1'b0;
			st_next.lead_state = TCOSP_IDLE;
			st_next.follow_state = TCOSP_IDLE;
			st_next.delay_down_counter = '0;
			st_next.width_down_counter = '0;
			st_next.lead_irq_pend = 1'b0;
			st_next.soft_start = 1'b0;
			st_next.delay_done_irq = 1'b0;
			st_next.width_done_irq = 1'b0;
		end

		// The pin level always shows the stored output bit; counting updates that bit only while enabled.
		st_next.pulse_out = st_next.out_value[TCOSP_FOLLOW_BIT];
		st_next.pulse_out_oe = st_next.unit_en && st_next.out_role[TCOSP_FOLLOW_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign pulse_out = st_reg.pulse_out;
	assign pulse_out_oe = st_reg.pulse_out_oe;
	assign delay_done_irq = st_reg.delay_done_irq;
	assign width_done_irq = st_reg.width_done_irq;

	property p_stop_holds;
		@(posedge pclk) disable iff (!presetn)
		(apb_wr && paddr == TCOSP_OFF_STOP && pwdata[TCOSP_LEAD_BIT] && st_reg.unit_en)
			|=> (!st_reg.lead_running_flag && $stable(st_reg.delay_down_counter));
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stop did not hold lead counter");
	property p_start_flags;
		@(posedge pclk) disable iff (!presetn)
		(apb_wr && paddr == TCOSP_OFF_START && pwdata[1:0] == 2'h3 && st_reg.unit_en)
			|=> (st_reg.lead_running_flag && st_reg.follow_running_flag);
	endproperty
	a_start_flags: assert property (p_start_flags) else $error("start did not set running flags");
	property p_width_irq_zero;
		@(posedge pclk) disable iff (!presetn)
		(width_done_irq && !$past(apb_wr && paddr == TCOSP_OFF_STOP)) |-> st_reg.width_down_counter == '0;
	endproperty
	a_width_irq_zero: assert property (p_width_irq_zero) else $error("width irq with counter not at zero");
	property p_unit_off;
		@(posedge pclk) disable iff (!presetn)
		!st_reg.unit_en |-> (!pulse_out && !pulse_out_oe && !st_reg.lead_running_flag);
	endproperty
	a_unit_off: assert property (p_unit_off) else $error("unit disabled but state not cleared");
endmodule

// ===== tb/tcosp_pin_model.sv
// Trigger pin source and pulse pin observer for the one-shot timer pair.
`timescale 1ns/1ps
module tcosp_pin_model (
	input wire logic pclk,
	input wire logic pulse_out,
	input wire logic delay_done_irq,
	input wire logic width_done_irq,
	output logic trigger_in
);
	initial trigger_in = 1'b0;

	task automatic set_pin(input logic v);
		@(posedge pclk);
		trigger_in <= v;
	endtask

	// Drives the pin, then counts edges to pulse start and pulse length, with the irq pulses seen.
	task automatic shot(input logic lvl, input logic inact, output int d, output int w, output int nd, output int nw);
		d = 0;
		w = 0;
		nd = 0;
		nw = 0;
		@(posedge pclk);
		trigger_in <= lvl;
		while (pulse_out === inact && d < 3000)
		begin
			@(posedge pclk);
			d++;
			nd += int'(delay_done_irq === 1'b1);
		end
		while (pulse_out !== inact && w < 3000)
		begin
			@(posedge pclk);
			w++;
			nw += int'(width_done_irq === 1'b1);
		end
		// The finish irq is registered on the same edge that ends the pulse; three more cycles are still watched.
		repeat (3)
		begin
			@(posedge pclk);
			nw += int'(width_done_irq === 1'b1);
		end
	endtask
endmodule

// ===== tb/test_two_channel_one_shot_pulse.sv
// Self-checking bench of the one-shot pulse timer pair.
`timescale 1ns/1ps
module test_two_channel_one_shot_pulse;
	import tcosp_pkg::*;
	typedef struct {logic [1:0] esel; logic pol; logic [1:0] cks; logic [15:0] dly; logic [15:0] wid;} tcosp_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trigger_in;
	logic pulse_out, pulse_out_oe, delay_done_irq, width_done_irq, e, idle;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, v1, v2;
	int n_fail = 0;
	int n_tests = 0;
	int d, w, nd, nw, p, off;
	// Three clocks of pin synchronisation and edge detection, one more to see the registered pin.
	int base = 4;
	tcosp_row_s rows [4] = '{
		'{TCOSP_EDGE_FALL, 1'b0, TCOSP_CKS_A, 16'h0003, 16'h0002},
		'{TCOSP_EDGE_RISE, 1'b1, TCOSP_CKS_B, 16'h0005, 16'h0001},
		'{TCOSP_EDGE_BOTH, 1'b0, TCOSP_CKS_A, 16'h0000, 16'h0004},
		'{TCOSP_EDGE_BOTH, 1'b1, TCOSP_CKS_B, 16'h0002, 16'h0003}};

	tcosp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_in(trigger_in), .pulse_out(pulse_out), .pulse_out_oe(pulse_out_oe),
		.delay_done_irq(delay_done_irq), .width_done_irq(width_done_irq));
	tcosp_pin_model i_pins (.pclk(pclk), .pulse_out(pulse_out), .delay_done_irq(delay_done_irq),
		.width_done_irq(width_done_irq), .trigger_in(trigger_in));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dv;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50)
			ck(32'h0, 32'h1, "apb hang");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		apb(1'b1, a, dv, v1, e);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, v1, e);
		ck(v1, exp, "register");
	endtask

	// Programs the pair while stopped; mode fields are only changed here.
	task automatic setup(input tcosp_row_s r, input logic lvl);
		logic [31:0] cks;
		cks = 32'(r.cks) << TCOSP_CKS_LO;
		i_pins.set_pin(lvl);
		wr(TCOSP_OFF_CTRL, 32'h0000_0000);
		wr(TCOSP_OFF_CTRL, 32'h0000_0001);
		wr(TCOSP_OFF_PRESCALE, 32'h0002_0000);
		wr(TCOSP_OFF_MODE_LEAD, cks | (32'(r.esel) << TCOSP_CIS_LO) | (32'(TCOSP_STS_PIN) << TCOSP_STS_LO)
			| 32'(TCOSP_MD_ONE_COUNT));
		wr(TCOSP_OFF_MODE_FOLLOW, cks | (32'(TCOSP_STS_LEAD_IRQ) << TCOSP_STS_LO) | 32'(TCOSP_MD_ONE_COUNT));
		wr(TCOSP_OFF_DELAY_RELOAD, {16'h0000, r.dly});
		wr(TCOSP_OFF_WIDTH_RELOAD, {16'h0000, r.wid});
		wr(TCOSP_OFF_OUT_ROLE, 32'h0000_0002);
		wr(TCOSP_OFF_OUT_POLARITY, {30'h0, r.pol, 1'b0});
		wr(TCOSP_OFF_OUT_VALUE, {30'h0, r.pol, 1'b0});
		wr(TCOSP_OFF_OUT_ENABLE, 32'h0000_0002);
		wr(TCOSP_OFF_START, 32'h0000_0003);
		chk(TCOSP_OFF_START, 32'h0000_0000);
		chk(TCOSP_OFF_STATUS, 32'h0000_0003);
	endtask

	initial
	begin
		#200000;
		n_fail++;
		stop_test();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		ck({28'h0, pulse_out, pulse_out_oe, delay_done_irq, width_done_irq}, 32'h0, "reset outputs");
		chk(TCOSP_OFF_CTRL, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			idle = (rows[i].esel == TCOSP_EDGE_FALL) || (i == 3);
			p = (rows[i].cks == TCOSP_CKS_B) ? 3 : 1;
			setup(rows[i], idle);
			ck(32'(pulse_out_oe), 32'h1, "oe");
			i_pins.shot(~idle, rows[i].pol, d, w, nd, nw);
			off = d - (int'(rows[i].dly) + 2) * p;
			ck(32'(off >= 0 && off <= p + 5 && (p > 1 || off == base)), 32'h1, "delay");
			ck(32'(w), 32'(int'(rows[i].wid) * p), "width");
			ck(32'(nd), 32'h1, "lead irq");
			ck(32'(nw), 32'h1, "follower irq");
			chk(TCOSP_OFF_DELAY_COUNT, 32'h0000_0000);
		end
		// A second edge in mid-count must not restart the delay.
		setup('{TCOSP_EDGE_RISE, 1'b0, TCOSP_CKS_A, 16'h0014, 16'h0002}, 1'b0);
		fork
			i_pins.shot(1'b1, 1'b0, d, w, nd, nw);
			begin
				repeat (6) @(posedge pclk);
				i_pins.set_pin(1'b0);
				repeat (2) @(posedge pclk);
				i_pins.set_pin(1'b1);
			end
		join
		ck(32'(d - 22), 32'(base), "retrigger");
		fork
			i_pins.shot(1'b1, 1'b0, d, w, nd, nw);
			wr(TCOSP_OFF_START, 32'h0000_0001);
		join
		ck(32'(w == 2 && d - 22 == base), 32'h1, "soft start");
		i_pins.set_pin(1'b0);
		repeat (4) @(posedge pclk);
		i_pins.set_pin(1'b1);
		repeat (12) @(posedge pclk);
		wr(TCOSP_OFF_STOP, 32'h0000_0003);
		chk(TCOSP_OFF_STATUS, 32'h0000_0000);
		apb(1'b0, TCOSP_OFF_DELAY_COUNT, 32'h0, v2, e);
		repeat (40) @(posedge pclk);
		chk(TCOSP_OFF_DELAY_COUNT, v2);
		ck(32'(v2 != 32'h0), 32'h1, "count held");
		ck(32'(pulse_out), 32'h0, "held output");
		wr(TCOSP_OFF_OUT_ENABLE, 32'h0000_0000);
		wr(TCOSP_OFF_OUT_VALUE, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		ck(32'(pulse_out), 32'h1, "stored high");
		wr(TCOSP_OFF_OUT_VALUE, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		ck(32'(pulse_out), 32'h0, "stored low");
		apb(1'b0, 8'h3C, 32'h0, v1, e);
		ck(32'(e), 32'h1, "unmapped");
		wr(TCOSP_OFF_OUT_VALUE, 32'h0000_0002);
		wr(TCOSP_OFF_CTRL, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		ck({30'h0, pulse_out, pulse_out_oe}, 32'h0, "unit off pins");
		chk(TCOSP_OFF_OUT_VALUE, 32'h0000_0000);
		chk(TCOSP_OFF_STATUS, 32'h0000_0000);
		stop_test();
	end
endmodule
